// ---- design/vob_pkg.sv ----
`default_nettype none
package vob_pkg;
   // Instance numbers of the attribute bank
   localparam logic [7:0] INST_CLASS  = 8'h00;
   localparam logic [7:0] INST_INPUT  = 8'h01;
   localparam logic [7:0] INST_CRC    = 8'h02;
   localparam logic [7:0] INST_STATUS = 8'h03;
   localparam logic [7:0] INST_AUX    = 8'h04;
   localparam logic [7:0] INST_MODE   = 8'h05;
   localparam logic [7:0] INST_ERRQ   = 8'h06;
   localparam logic [7:0] INST_OUTPUT = 8'h07;
   // Class descriptor values
   localparam logic [47:0] CLS_REVISION  = 48'h0000_0000_0001;
   localparam logic [47:0] CLS_MAX_INST  = 48'h0000_0000_0004;
   localparam logic [47:0] CLS_NUM_INST  = 48'h0000_0000_0004;
   localparam logic [47:0] CLS_SERVICES  = 48'h004d_004c_0002;
   localparam logic [47:0] CLS_MAX_CATTR = 48'h0000_0000_0007;
   localparam logic [47:0] CLS_MAX_IATTR = 48'h0000_0000_003c;
   // Class attribute ids
   localparam logic [7:0] CATTR_REV  = 8'h01;
   localparam logic [7:0] CATTR_MAXI = 8'h02;
   localparam logic [7:0] CATTR_NUMI = 8'h03;
   localparam logic [7:0] CATTR_SVC  = 8'h05;
   localparam logic [7:0] CATTR_MAXC = 8'h06;
   localparam logic [7:0] CATTR_MAXA = 8'h07;
   // Attribute counts per instance
   localparam logic [7:0] N_IN_BYTES  = 8'h32;
   localparam logic [7:0] N_OUT_BYTES = 8'h32;
   localparam logic [7:0] N_STATUS    = 8'h3c;
   localparam logic [7:0] N_AUX       = 8'h3c;
   localparam logic [7:0] N_CRC_ATTR  = 8'h08;
   localparam logic [7:0] N_ERRQ      = 8'h05;
   localparam int         ERRQ_DEPTH  = 5;
   localparam int         OUT_DEPTH   = 50;
   localparam int         STAT_EXT    = 52;
   // Answer lengths in bytes
   localparam logic [2:0] LEN_NONE = 3'h0;
   localparam logic [2:0] LEN_BYTE = 3'h1;
   localparam logic [2:0] LEN_UINT = 3'h2;
   localparam logic [2:0] LEN_WORD = 3'h4;
   localparam logic [2:0] LEN_SVC  = 3'h6;
   // Status byte reserved fill
   localparam logic RSVD_BIT = 1'b1;

   // Answer codes
   typedef enum logic [1:0] {
      VOB_OK       = 2'h0,
      VOB_NO_ATTR  = 2'h1,
      VOB_READONLY = 2'h2,
      VOB_BAD_VAL  = 2'h3
   } vob_sts_t;

   // One get or set request
   typedef struct packed {
      logic        set_req;
      logic [7:0]  inst;
      logic [7:0]  attr;
      logic [31:0] wdata;
   } vob_req_t;

   // One answer
   typedef struct packed {
      vob_sts_t    status;
      logic [2:0]  len;
      logic [47:0] data;
   } vob_rsp_t;

   // Health sources for status bytes 0 to 6, 1 = healthy
   typedef struct packed {
      logic        supply_group_b_second;
      logic        fast_shutoff_ok;
      logic        supply_group_b_first;
      logic        config_ok;
      logic        supply_group_a_state;
      logic        ext_module_ok;
      logic        int_module_ok;
      logic        out_data_ok;
      logic        in_data_ok;
      logic [3:0]  current_ok;
      logic [15:0] pulse_match_inputs;
      logic [3:0]  pulse_match_dual;
      logic [7:0]  pair_inputs;
      logic [1:0]  pair_dual;
   } vob_stat_src_t;
endpackage
`default_nettype wire

// ---- design/vob_out_mem.sv ----
`default_nettype none
// Output byte store shared by the attribute and the assembly path
module vob_out_mem (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [5:0] wr_addr,
   input  wire logic [7:0] wr_data,
   // Attribute read port
   input  wire logic [5:0] rd_a_addr,
   output logic      [7:0] rd_a_data,
   // Assembly read port
   input  wire logic       rd_b_en,
   input  wire logic [5:0] rd_b_addr,
   output logic      [7:0] rd_b_data
);
   logic [7:0] mem_reg [vob_pkg::OUT_DEPTH];   // Byte array
   logic [7:0] rd_a_next;                      // Attribute read value
   logic [7:0] rd_b_next;                      // Assembly read value

   // Read selection, out of range reads zero
   always_comb begin
      rd_a_next = 8'h00;
      rd_b_next = rd_b_data;
      if (rd_a_addr < 6'(vob_pkg::OUT_DEPTH)) begin
         rd_a_next = mem_reg[rd_a_addr];
      end
      if (rd_b_en) begin
         rd_b_next = (rd_b_addr < 6'(vob_pkg::OUT_DEPTH)) ? mem_reg[rd_b_addr] : 8'h00;
      end
   end

   // Storage and registered read data
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_a_data <= 8'h00;
         rd_b_data <= 8'h00;
         for (int i = 0; i < vob_pkg::OUT_DEPTH; i++) begin
            mem_reg[i] <= 8'h00;
         end
      end else begin
         rd_a_data <= rd_a_next;
         rd_b_data <= rd_b_next;
         if (wr_en && (wr_addr < 6'(vob_pkg::OUT_DEPTH))) begin
            mem_reg[wr_addr] <= wr_data;
         end
      end
   end
endmodule
`default_nettype wire

// ---- design/vob_bank.sv ----
`default_nettype none
// Behaviour
// - Class instance reports fixed read-only descriptors
// - Instance 1 returns fifty logic input bytes
// - Instance 7 holds fifty readable writable bytes
// - Instance 7 shares storage with assembly bytes
// - Instance 2 attribute 1 returns project CRC
// - Instance 2 attributes 2-8 read zero
// - Instance 3 returns sixty status bytes
// - Instance 4 sixty auxiliary bytes read zero
// - Instance 6 holds five error codes, newest first
// - Set zero to error attribute 1 clears queue
// - Status byte 0 health bit layout
// - Status byte 1 data and current layout
// - Status bytes 2,3 input pulse match flags
// - Status byte 4 dual terminal pulse match
// - Status byte 5 input pair states
// - Status byte 6 dual pairs, byte 7 reserved
// - Status bit one healthy, zero failure
// - Instance 5 returns encoded system mode
module vob_bank (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   // Attribute request and answer
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire vob_pkg::vob_req_t     req,
   output logic                       rsp_valid,
   output vob_pkg::vob_rsp_t          rsp,
   // Data and state from the controller logic
   input  wire logic [49:0][7:0]      in_bytes,
   input  wire logic [31:0]           crc_value,
   input  wire logic [7:0]            sys_mode,
   input  wire vob_pkg::vob_stat_src_t stat_src,
   input  wire logic [51:0][7:0]      stat_ext,
   // Error logging
   input  wire logic                  err_log,
   input  wire logic [31:0]           err_code,
   // Assembly path to the output bytes
   input  wire logic                  asm_wr,
   output logic                       asm_wr_ready,
   input  wire logic [5:0]            asm_addr,
   input  wire logic [7:0]            asm_wdata,
   input  wire logic                  asm_rd,
   output logic                       asm_rd_valid,
   output logic [7:0]                 asm_rdata
);
   // Stage one state
   logic                s1_valid_reg, s1_valid_next;     // Answer pending
   vob_pkg::vob_sts_t   s1_sts_reg, s1_sts_next;         // Answer code
   logic [2:0]          s1_len_reg, s1_len_next;         // Answer length
   logic [47:0]         s1_data_reg, s1_data_next;       // Non-memory data
   logic                s1_mem_reg, s1_mem_next;         // Data from output store
   // Answer state
   logic                rsp_valid_reg, rsp_valid_next;   // Answer strobe
   vob_pkg::vob_rsp_t   rsp_reg, rsp_next;               // Answer word
   logic                asm_rv_reg, asm_rv_next;         // Assembly read strobe
   // Error queue
   logic [31:0]         errq_reg  [vob_pkg::ERRQ_DEPTH]; // Entry 0 newest
   logic [31:0]         errq_next [vob_pkg::ERRQ_DEPTH];
   logic [31:0]         errq_base [vob_pkg::ERRQ_DEPTH]; // After clear
   logic                errq_clear;                      // Clear request
   // Output store access
   logic                attr_wr;                         // Attribute write
   logic [5:0]          attr_idx;                        // Attribute byte index
   logic [7:0]          mem_rd_a;                        // Attribute read data
   // Decode helpers
   logic [7:0]          idx;                             // Attribute minus one
   logic                exists;                          // Attribute present
   logic                writable;                        // Attribute settable
   logic [59:0][7:0]    stat_bytes;                      // Status bytes 0 to 59

   assign req_ready    = 1'b1;
   assign rsp_valid    = rsp_valid_reg;
   assign rsp          = rsp_reg;
   assign asm_rd_valid = asm_rv_reg;
   assign idx          = req.attr - 8'h01;
   assign attr_idx     = idx[5:0];
   // Attribute write wins the shared write port
   assign asm_wr_ready = !attr_wr;

   // Status byte assembly, reserved bits forced to one
   always_comb begin
      stat_bytes[0] = {stat_src.supply_group_b_second, stat_src.fast_shutoff_ok,
                       stat_src.supply_group_b_first, stat_src.config_ok,
                       stat_src.supply_group_a_state, stat_src.ext_module_ok,
                       stat_src.int_module_ok, vob_pkg::RSVD_BIT};
      stat_bytes[1] = {stat_src.out_data_ok, stat_src.in_data_ok,
                       {2{vob_pkg::RSVD_BIT}}, stat_src.current_ok};
      stat_bytes[2] = stat_src.pulse_match_inputs[7:0];
      stat_bytes[3] = stat_src.pulse_match_inputs[15:8];
      stat_bytes[4] = {{4{vob_pkg::RSVD_BIT}}, stat_src.pulse_match_dual};
      stat_bytes[5] = stat_src.pair_inputs;
      stat_bytes[6] = {{6{vob_pkg::RSVD_BIT}}, stat_src.pair_dual};
      stat_bytes[7] = {8{vob_pkg::RSVD_BIT}};
      for (int i = 0; i < vob_pkg::STAT_EXT; i++) begin
         stat_bytes[i + 8] = stat_ext[i];
      end
   end

   // Request decode into stage one
   always_comb begin
      s1_valid_next = req_valid;
      s1_sts_next   = vob_pkg::VOB_NO_ATTR;
      s1_len_next   = vob_pkg::LEN_NONE;
      s1_data_next  = 48'h0000_0000_0000;
      s1_mem_next   = 1'b0;
      exists        = 1'b0;
      writable      = 1'b0;
      attr_wr       = 1'b0;
      errq_clear    = 1'b0;
      case (req.inst)
         vob_pkg::INST_CLASS: begin
            exists      = 1'b1;
            s1_len_next = vob_pkg::LEN_UINT;
            case (req.attr)
               vob_pkg::CATTR_REV:  s1_data_next = vob_pkg::CLS_REVISION;
               vob_pkg::CATTR_MAXI: s1_data_next = vob_pkg::CLS_MAX_INST;
               vob_pkg::CATTR_NUMI: s1_data_next = vob_pkg::CLS_NUM_INST;
               vob_pkg::CATTR_SVC: begin
                  s1_data_next = vob_pkg::CLS_SERVICES;
                  s1_len_next  = vob_pkg::LEN_SVC;
               end
               vob_pkg::CATTR_MAXC: s1_data_next = vob_pkg::CLS_MAX_CATTR;
               vob_pkg::CATTR_MAXA: s1_data_next = vob_pkg::CLS_MAX_IATTR;
               default:             exists = 1'b0;
            endcase
         end
         vob_pkg::INST_INPUT: begin
            // Logic input bytes
            exists      = (req.attr != 8'h00) && (req.attr <= vob_pkg::N_IN_BYTES);
            s1_len_next = vob_pkg::LEN_BYTE;
            if (exists) begin
               s1_data_next = {40'h00_0000_0000, in_bytes[attr_idx]};
            end
         end
         vob_pkg::INST_CRC: begin
            // CRC in attribute 1, the rest reserved as zero
            exists      = (req.attr != 8'h00) && (req.attr <= vob_pkg::N_CRC_ATTR);
            s1_len_next = vob_pkg::LEN_WORD;
            if (req.attr == 8'h01) begin
               s1_data_next = {16'h0000, crc_value};
            end
         end
         vob_pkg::INST_STATUS: begin
            exists      = (req.attr != 8'h00) && (req.attr <= vob_pkg::N_STATUS);
            s1_len_next = vob_pkg::LEN_BYTE;
            if (exists) begin
               s1_data_next = {40'h00_0000_0000, stat_bytes[attr_idx]};
            end
         end
         vob_pkg::INST_AUX: begin
            // Auxiliary bytes, always zero
            exists      = (req.attr != 8'h00) && (req.attr <= vob_pkg::N_AUX);
            s1_len_next = vob_pkg::LEN_BYTE;
         end
         vob_pkg::INST_MODE: begin
            exists      = (req.attr == 8'h01);
            s1_len_next = vob_pkg::LEN_BYTE;
            s1_data_next = {40'h00_0000_0000, sys_mode};
         end
         vob_pkg::INST_ERRQ: begin
            exists      = (req.attr != 8'h00) && (req.attr <= vob_pkg::N_ERRQ);
            writable    = (req.attr == 8'h01);
            s1_len_next = vob_pkg::LEN_WORD;
            if (exists) begin
               s1_data_next = {16'h0000, errq_reg[idx[2:0]]};
            end
         end
         vob_pkg::INST_OUTPUT: begin
            exists      = (req.attr != 8'h00) && (req.attr <= vob_pkg::N_OUT_BYTES);
            writable    = 1'b1;
            s1_len_next = vob_pkg::LEN_BYTE;
            s1_mem_next = exists && !req.set_req;
         end
         default: begin
            exists = 1'b0;
         end
      endcase
      // Outcome of the request
      if (!exists) begin
         s1_sts_next = vob_pkg::VOB_NO_ATTR;
         s1_len_next = vob_pkg::LEN_NONE;
         s1_data_next = 48'h0000_0000_0000;
      end else if (req.set_req && !writable) begin
         s1_sts_next = vob_pkg::VOB_READONLY;
         s1_len_next = vob_pkg::LEN_NONE;
         s1_data_next = 48'h0000_0000_0000;
      end else if (req.set_req && (req.inst == vob_pkg::INST_ERRQ) &&
                   (req.wdata != 32'h0000_0000)) begin
         // Only zero clears the queue
         s1_sts_next = vob_pkg::VOB_BAD_VAL;
         s1_len_next = vob_pkg::LEN_NONE;
         s1_data_next = 48'h0000_0000_0000;
      end else begin
         s1_sts_next = vob_pkg::VOB_OK;
         if (req.set_req) begin
            s1_len_next  = vob_pkg::LEN_NONE;
            s1_data_next = 48'h0000_0000_0000;
            attr_wr      = req_valid && (req.inst == vob_pkg::INST_OUTPUT);
            errq_clear   = req_valid && (req.inst == vob_pkg::INST_ERRQ);
         end
      end
   end

   // Error queue next value, a new error wins over the clear
   always_comb begin
      for (int i = 0; i < vob_pkg::ERRQ_DEPTH; i++) begin
         errq_base[i] = errq_clear ? 32'h0000_0000 : errq_reg[i];
         errq_next[i] = errq_base[i];
      end
      if (err_log) begin
         errq_next[0] = err_code;
         for (int i = 1; i < vob_pkg::ERRQ_DEPTH; i++) begin
            errq_next[i] = errq_base[i - 1];
         end
      end
   end

   // Answer stage next value
   always_comb begin
      rsp_valid_next = s1_valid_reg;
      rsp_next       = rsp_reg;
      asm_rv_next    = asm_rd;
      if (s1_valid_reg) begin
         rsp_next.status = s1_sts_reg;
         rsp_next.len    = s1_len_reg;
         rsp_next.data   = s1_mem_reg ? {40'h00_0000_0000, mem_rd_a} : s1_data_reg;
      end
   end

   // State registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_valid_reg  <= 1'b0;
         s1_sts_reg    <= vob_pkg::VOB_OK;
         s1_len_reg    <= vob_pkg::LEN_NONE;
         s1_data_reg   <= 48'h0000_0000_0000;
         s1_mem_reg    <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_reg       <= '0;
         asm_rv_reg    <= 1'b0;
         for (int i = 0; i < vob_pkg::ERRQ_DEPTH; i++) begin
            errq_reg[i] <= 32'h0000_0000;
         end
      end else begin
         s1_valid_reg  <= s1_valid_next;
         s1_sts_reg    <= s1_sts_next;
         s1_len_reg    <= s1_len_next;
         s1_data_reg   <= s1_data_next;
         s1_mem_reg    <= s1_mem_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_reg       <= rsp_next;
         asm_rv_reg    <= asm_rv_next;
         for (int i = 0; i < vob_pkg::ERRQ_DEPTH; i++) begin
            errq_reg[i] <= errq_next[i];
         end
      end
   end

   // Shared output byte store
   vob_out_mem u_out_mem (
      .mclk      (mclk),
      .nrst      (nrst),
      .wr_en     (attr_wr || asm_wr),
      .wr_addr   (attr_wr ? attr_idx : asm_addr),
      .wr_data   (attr_wr ? req.wdata[7:0] : asm_wdata),
      .rd_a_addr (attr_idx),
      .rd_a_data (mem_rd_a),
      .rd_b_en   (asm_rd),
      .rd_b_addr (asm_addr),
      .rd_b_data (asm_rdata)
   );

   // Checks
   property p_class_rev;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && !req.set_req && req.inst == 8'h00 && req.attr == 8'h01)
      |-> ##2 (rsp_valid && rsp.status == vob_pkg::VOB_OK && rsp.data == 48'h0000_0000_0001);
   endproperty
   a_class_rev: assert property (p_class_rev) else $error("class revision wrong");

   property p_svc_list;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && !req.set_req && req.inst == 8'h00 && req.attr == 8'h05)
      |-> ##2 (rsp.len == 3'h6 && rsp.data == 48'h004d_004c_0002);
   endproperty
   a_svc_list: assert property (p_svc_list) else $error("service list wrong");

   property p_crc;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && !req.set_req && req.inst == 8'h02 && req.attr == 8'h01)
      |-> ##2 (rsp.data[31:0] == $past(crc_value, 2));
   endproperty
   a_crc: assert property (p_crc) else $error("crc not returned");

   property p_crc_rsvd;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && !req.set_req && req.inst == 8'h02 && req.attr >= 8'h02 && req.attr <= 8'h08)
      |-> ##2 (rsp.status == vob_pkg::VOB_OK && rsp.data == 48'h0000_0000_0000);
   endproperty
   a_crc_rsvd: assert property (p_crc_rsvd) else $error("reserved crc not zero");

   property p_aux_zero;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && !req.set_req && req.inst == 8'h04 && req.attr == 8'h3c)
      |-> ##2 (rsp.status == vob_pkg::VOB_OK && rsp.data == 48'h0000_0000_0000);
   endproperty
   a_aux_zero: assert property (p_aux_zero) else $error("aux byte not zero");

   property p_mode;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && !req.set_req && req.inst == 8'h05 && req.attr == 8'h01)
      |-> ##2 (rsp.data[7:0] == $past(sys_mode, 2));
   endproperty
   a_mode: assert property (p_mode) else $error("system mode wrong");

   property p_ro_refused;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && req.set_req && req.inst == 8'h03 && req.attr == 8'h01)
      |-> ##2 (rsp_valid && rsp.status == vob_pkg::VOB_READONLY);
   endproperty
   a_ro_refused: assert property (p_ro_refused) else $error("read-only set taken");

   property p_rsvd_bit;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && !req.set_req && req.inst == 8'h03 && req.attr == 8'h08)
      |-> ##2 (rsp.data[7:0] == 8'hff);
   endproperty
   a_rsvd_bit: assert property (p_rsvd_bit) else $error("reserved status not ones");

   property p_clear;
      @(posedge mclk) disable iff (!nrst)
      (errq_clear && !err_log) |=> (errq_reg[0] == 32'h0000_0000 && errq_reg[4] == 32'h0000_0000);
   endproperty
   a_clear: assert property (p_clear) else $error("queue not cleared");

   property p_shift;
      @(posedge mclk) disable iff (!nrst)
      (err_log && !errq_clear)
      |=> (errq_reg[0] == $past(err_code) && errq_reg[1] == $past(errq_reg[0])
           && errq_reg[4] == $past(errq_reg[3]));
   endproperty
   a_shift: assert property (p_shift) else $error("error queue shift wrong");

   property p_out_prio;
      @(posedge mclk) disable iff (!nrst)
      (req_valid && req.set_req && req.inst == 8'h07 && req.attr == 8'h01) |-> !asm_wr_ready;
   endproperty
   a_out_prio: assert property (p_out_prio) else $error("assembly write not held");
endmodule
`default_nettype wire

// ---- test/vob_ctrl_model.sv ----
`default_nettype none
// Remote controller: issues one get or set and waits for its answer
module vob_ctrl_model (
   // Clock
   input  wire logic              mclk,
   // Attribute request and answer
   output logic                   req_valid,
   output var vob_pkg::vob_req_t  req,
   input  wire logic              rsp_valid,
   input  wire vob_pkg::vob_rsp_t rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle before the first request
   initial begin
      req_valid = 1'b0;
      req       = '0;
   end
   // Request held for one taking edge, answer awaited under a bound
   task automatic xfer(input logic s, input logic [7:0] i, input logic [7:0] a,
                       input logic [31:0] w, output vob_pkg::vob_rsp_t r);
      r = 'x;
      @(posedge mclk);
      req_valid <= 1'b1;
      req       <= '{s, i, a, w};
      @(posedge mclk);
      req_valid <= 1'b0;
      // Released request lines show the inverse, not the last value
      req       <= ~req;
      for (int k = 0; k < 6; k++) begin
         @(posedge mclk);
         if (rsp_valid === 1'b1) begin
            r = rsp;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`default_nettype none
// Self-checking bench for the attribute bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, nrst, req_valid, req_ready, rsp_valid, err_log;
   logic asm_wr, asm_wr_ready, asm_rd, asm_rd_valid;
   vob_pkg::vob_req_t      req;
   vob_pkg::vob_rsp_t      rsp;
   vob_pkg::vob_stat_src_t ss;
   logic [49:0][7:0]       in_b;
   logic [51:0][7:0]       s_ext;
   logic [31:0]            crc, e_code;
   logic [7:0]             mode, asm_wd, asm_rdata;
   logic [5:0]             asm_a;
   int                     num_errors, total_checks;
   // Design and controller model
   vob_bank dut_u (.mclk, .nrst, .req_valid, .req_ready, .req, .rsp_valid, .rsp,
      .in_bytes(in_b), .crc_value(crc), .sys_mode(mode), .stat_src(ss), .stat_ext(s_ext),
      .err_log, .err_code(e_code), .asm_wr, .asm_wr_ready, .asm_addr(asm_a),
      .asm_wdata(asm_wd), .asm_rd, .asm_rd_valid, .asm_rdata);
   vob_ctrl_model ctl_u (.mclk, .req_valid, .req, .rsp_valid, .rsp);
   // Compare and count
   task automatic chk(input logic [52:0] g, input logic [52:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Access; status, length and data are compared on every access
   task automatic acc(input logic s, input logic [7:0] i, input logic [7:0] a,
      input logic [31:0] w, input vob_pkg::vob_sts_t st, input logic [2:0] ln,
      input logic [47:0] d);
      vob_pkg::vob_rsp_t r;
      ctl_u.xfer(s, i, a, w, r);
      chk({r.status, r.len, r.data}, {st, ln, d});
   endtask
   task automatic get(input logic [7:0] i, input logic [7:0] a, input logic [2:0] ln,
      input logic [31:0] d);
      acc(1'b0, i, a, 32'h0, vob_pkg::VOB_OK, ln, {16'h0, d});
   endtask
   // Assembly path read, answer one cycle after the taking edge
   task automatic asm_read(input logic [5:0] a, input logic [7:0] d);
      @(posedge mclk);
      asm_rd <= 1'b1;
      asm_a  <= a;
      @(posedge mclk);
      asm_rd <= 1'b0;
      @(posedge mclk);
      chk({45'h0, asm_rd_valid, asm_rdata}, {45'h0, 1'b1, d});
   endtask
   // Expected status byte from the health sources
   function automatic logic [7:0] sbyte(int n);
      case (n)
         0: return {ss.supply_group_b_second, ss.fast_shutoff_ok, ss.supply_group_b_first,
                    ss.config_ok, ss.supply_group_a_state, ss.ext_module_ok,
                    ss.int_module_ok, 1'b1};
         1: return {ss.out_data_ok, ss.in_data_ok, 2'h3, ss.current_ok};
         2: return ss.pulse_match_inputs[7:0];
         3: return ss.pulse_match_inputs[15:8];
         4: return {4'hf, ss.pulse_match_dual};
         5: return ss.pair_inputs;
         6: return {6'h3f, ss.pair_dual};
         7: return 8'hff;
         default: return s_ext[n-8];
      endcase
   endfunction
   task finish_test;
      if (num_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Watchdog
   initial begin
      #100_000;
      num_errors++;
      finish_test;
   end
   // Main sequence
   initial begin
      static logic [7:0] mc[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h15};
      {nrst, err_log, asm_wr, asm_rd, asm_a, asm_wd, mode, e_code} = '0;
      crc = 32'hffff_ffff;
      ss  = 43'h5a3_c96e_1b27;
      for (int n = 0; n < 52; n++) s_ext[n] = 8'(n) + 8'h80;
      for (int n = 0; n < 50; n++) in_b[n] = 8'(n) ^ 8'h5a;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      get(8'h06, 8'h01, 3'h4, 32'h0);
      get(8'h07, 8'h01, 3'h1, 32'h0);
      get(8'h00, 8'h01, 3'h2, 32'h1);
      get(8'h00, 8'h02, 3'h2, 32'h4);
      get(8'h00, 8'h03, 3'h2, 32'h4);
      acc(1'b0, 8'h00, 8'h05, 32'h0, vob_pkg::VOB_OK, 3'h6, 48'h004d_004c_0002);
      get(8'h00, 8'h06, 3'h2, 32'h7);
      get(8'h00, 8'h07, 3'h2, 32'h3c);
      acc(1'b1, 8'h00, 8'h01, 32'h9, vob_pkg::VOB_READONLY, 3'h0, 48'h0);
      for (int n = 0; n < 50; n++) get(8'h01, 8'(n + 1), 3'h1, {24'h0, in_b[n]});
      acc(1'b0, 8'h01, 8'h33, 32'h0, vob_pkg::VOB_NO_ATTR, 3'h0, 48'h0);
      get(8'h02, 8'h01, 3'h4, crc);
      for (int a = 2; a < 9; a++) get(8'h02, 8'(a), 3'h4, 32'h0);
      acc(1'b1, 8'h02, 8'h01, 32'h0, vob_pkg::VOB_READONLY, 3'h0, 48'h0);
      acc(1'b1, 8'h03, 8'h01, 32'h0, vob_pkg::VOB_READONLY, 3'h0, 48'h0);
      for (int p = 0; p < 2; p++) begin
         // New sources settle before the first expected byte is formed
         ss <= ~ss;
         @(posedge mclk);
         for (int n = 0; n < 60; n++)
            get(8'h03, 8'(n + 1), 3'h1, {24'h0, sbyte(n)});
      end
      for (int n = 0; n < 60; n++) get(8'h04, 8'(n + 1), 3'h1, 32'h0);
      acc(1'b0, 8'h04, 8'h3d, 32'h0, vob_pkg::VOB_NO_ATTR, 3'h0, 48'h0);
      foreach (mc[k]) begin
         @(posedge mclk);
         mode <= mc[k];
         get(8'h05, 8'h01, 3'h1, {24'h0, mc[k]});
      end
      for (int k = 0; k < 6; k++) begin
         @(posedge mclk);
         err_log <= 1'b1;
         e_code  <= 32'hc0de_0000 | 32'(k);
      end
      @(posedge mclk);
      err_log <= 1'b0;
      for (int a = 1; a < 6; a++) get(8'h06, 8'(a), 3'h4, 32'hc0de_0000 | 32'(6 - a));
      acc(1'b1, 8'h06, 8'h01, 32'h1, vob_pkg::VOB_BAD_VAL, 3'h0, 48'h0);
      acc(1'b1, 8'h06, 8'h02, 32'h0, vob_pkg::VOB_READONLY, 3'h0, 48'h0);
      get(8'h06, 8'h01, 3'h4, 32'hc0de_0005);
      // Clear and new error in one cycle: new error kept, older ones gone
      fork
         acc(1'b1, 8'h06, 8'h01, 32'h0, vob_pkg::VOB_OK, 3'h0, 48'h0);
         begin
            @(posedge mclk);
            err_log <= 1'b1;
            e_code  <= 32'h0bad_0001;
            @(posedge mclk);
            err_log <= 1'b0;
         end
      join
      get(8'h06, 8'h01, 3'h4, 32'h0bad_0001);
      get(8'h06, 8'h02, 3'h4, 32'h0);
      acc(1'b1, 8'h06, 8'h01, 32'h0, vob_pkg::VOB_OK, 3'h0, 48'h0);
      for (int a = 1; a < 6; a++) get(8'h06, 8'(a), 3'h4, 32'h0);
      acc(1'b0, 8'h06, 8'h06, 32'h0, vob_pkg::VOB_NO_ATTR, 3'h0, 48'h0);
      acc(1'b1, 8'h07, 8'h01, 32'ha1, vob_pkg::VOB_OK, 3'h0, 48'h0);
      acc(1'b1, 8'h07, 8'h32, 32'hb2, vob_pkg::VOB_OK, 3'h0, 48'h0);
      acc(1'b1, 8'h07, 8'h33, 32'hc3, vob_pkg::VOB_NO_ATTR, 3'h0, 48'h0);
      get(8'h07, 8'h32, 3'h1, 32'hb2);
      asm_read(6'h00, 8'ha1);
      asm_read(6'h31, 8'hb2);
      @(posedge mclk);
      asm_wr <= 1'b1;
      asm_a  <= 6'h0a;
      asm_wd <= 8'h3c;
      @(posedge mclk);
      asm_wr <= 1'b0;
      get(8'h07, 8'h0b, 3'h1, 32'h3c);
      get(8'h07, 8'h01, 3'h1, 32'ha1);
      asm_read(6'h32, 8'h00);
      // Attribute and assembly write in one cycle: attribute path wins
      fork
         acc(1'b1, 8'h07, 8'h05, 32'h55, vob_pkg::VOB_OK, 3'h0, 48'h0);
         begin
            @(posedge mclk);
            asm_wr <= 1'b1;
            asm_a  <= 6'h04;
            asm_wd <= 8'h77;
            @(posedge mclk);
            chk({51'h0, req_ready, asm_wr_ready}, {51'h0, 2'b10});
            asm_wr <= 1'b0;
         end
      join
      asm_read(6'h04, 8'h55);
      acc(1'b1, 8'h01, 8'h01, 32'h0, vob_pkg::VOB_READONLY, 3'h0, 48'h0);
      get(8'h01, 8'h01, 3'h1, {24'h0, in_b[0]});
      finish_test;
   end
endmodule
`default_nettype wire
